// file: logic/lier_top.sv
// Purpose: enable, pending and INTx pin gating of the local interrupt sources
// Assumes: event inputs are pclk-domain pulses; request lines come from pins
// Notes:   zero-wait APB slave; read data captured in the setup cycle

`timescale 1ns/1ps

module lier_top #(
  parameter int unsigned N_PINS = 4
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire lier_pkg::lier_apb_req_t     apb_req,
  output lier_pkg::lier_apb_rsp_t          apb_rsp,
  input  wire logic [lier_pkg::DATA_W-1:0] src_event,
  input  wire logic [lier_pkg::LEVEL_CNT:1] irq_line_n,
  input  wire logic [lier_pkg::DATA_W*$clog2(N_PINS)-1:0] pin_map,
  output logic      [N_PINS-1:0]           intx_assert,
  output logic                             irq
);
  import lier_pkg::*;

  localparam int unsigned SEL_W = $clog2(N_PINS);

  typedef struct packed {
    logic [DATA_W-1:0] en;
    logic [DATA_W-1:0] gate;
    logic [DATA_W-1:0] pend;
    logic [DATA_W-1:0] mask;
    logic [N_PINS-1:0] intx;
    logic              irq;
    logic [DATA_W-1:0] rdata;
    logic              err;
  } lier_top_st_t;

  lier_top_st_t st_reg;
  lier_top_st_t st_next;

  // Pin select must address every pin exactly
  if (N_PINS < 2 || (1 << SEL_W) != N_PINS) begin : g_bad_pins
    $error("N_PINS must be a power of two of at least two");
  end

  logic [LEVEL_CNT-1:0] seen_n;
  logic [DATA_W-1:0]    lvl_vec;
  logic                 acc_wr;
  logic                 setup_rd;
  logic                 addr_ok;
  logic [DATA_W-1:0]    wmask;
  logic [DATA_W-1:0]    clr_bits;

  lier_sync #(
    .WIDTH (LEVEL_CNT)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .line_n  (irq_line_n),
    .seen_n  (seen_n)
  );

  assign lvl_vec = {{(DATA_W-LEVEL_CNT-1){1'b0}}, ~seen_n, 1'b0};

  // Write lands on the access edge, pready is always high
  assign acc_wr   = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  always_comb begin
    unique case (apb_req.paddr)
      OFS_SOURCE_ENABLE,
      OFS_PIN_GATE,
      OFS_PENDING_FLAGS,
      OFS_PENDING_CLEAR,
      OFS_HOST_MASK: addr_ok = 1'b1;
      default:       addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    wmask = '0;
    for (int unsigned b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{apb_req.pstrb[b]}};
    end
  end

  assign clr_bits = (acc_wr && apb_req.paddr == OFS_PENDING_CLEAR)
                  ? (apb_req.pwdata & wmask & EVENT_BITS) : '0;

  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] old_v,
                                              logic [DATA_W-1:0] mask_v);
    return ((old_v & ~wmask) | (apb_req.pwdata & wmask)) & mask_v;
  endfunction

  always_comb begin
    st_next = st_reg;

    if (acc_wr) begin
      unique case (apb_req.paddr)
        OFS_SOURCE_ENABLE: st_next.en = merge(st_reg.en, VALID_BITS);
        OFS_PIN_GATE:      st_next.gate = merge(st_reg.gate, VALID_BITS);
        OFS_HOST_MASK:     st_next.mask = merge(st_reg.mask, VALID_BITS);
        default:           st_next.mask = st_reg.mask;
      endcase
    end

    st_next.pend = ((((st_reg.pend & ~clr_bits) | src_event) & EVENT_BITS)
                 | (lvl_vec & LEVEL_BITS)) & st_next.en;

    st_next.intx = '0;
    for (int unsigned i = 0; i < DATA_W; i++) begin
      if (st_next.pend[i] && st_next.gate[i] && st_next.en[i]) begin
        st_next.intx[pin_map[i*SEL_W +: SEL_W]] = 1'b1;
      end
    end

    st_next.irq = |(st_next.pend & st_next.mask);

    if (setup_rd) begin
      st_next.err = ~addr_ok | (apb_req.paddr[1:0] != 2'b00);
      unique case (apb_req.paddr)
        OFS_SOURCE_ENABLE: st_next.rdata = st_reg.en;
        OFS_PIN_GATE:      st_next.rdata = st_reg.gate;
        OFS_PENDING_FLAGS: st_next.rdata = st_reg.pend;
        OFS_HOST_MASK:     st_next.rdata = st_reg.mask;
        default:           st_next.rdata = RST_WORD;
      endcase
    end else if (apb_req.psel && !apb_req.penable) begin
      st_next.err   = ~addr_ok;
      st_next.rdata = RST_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.en    <= RST_WORD;
      st_reg.gate  <= RST_WORD;
      st_reg.pend  <= RST_WORD;
      st_reg.mask  <= RST_WORD;
      st_reg.intx  <= '0;
      st_reg.irq   <= 1'b0;
      st_reg.rdata <= RST_WORD;
      st_reg.err   <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Error only shows in the access phase
  assign apb_rsp.prdata  = st_reg.rdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = st_reg.err & apb_req.psel & apb_req.penable;
  assign intx_assert     = st_reg.intx;
  assign irq             = st_reg.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_disabled_silent:
    assert property ((st_reg.pend & ~st_reg.en) == '0)
    else $error("pending flag set on a disabled source");

  chk_gate_blocks_pin:
    assert property ((st_reg.intx != '0) |->
                     ((st_reg.pend & st_reg.gate & st_reg.en) != '0))
    else $error("pin asserted without a gated pending source");

  chk_poll_quiet:
    assert property ((st_reg.gate == '0) |-> (st_reg.intx == '0))
    else $error("pin asserted while every pin gate is clear");

  chk_level_track:
    assert property (1'b1 |=>
                     ((st_reg.pend & LEVEL_BITS) ==
                      ($past(lvl_vec) & st_reg.en & LEVEL_BITS)))
    else $error("level flag does not follow its request line");

  chk_single_pin:
    assert property (($countones(st_reg.pend & st_reg.gate) == 1) |->
                     $onehot(st_reg.intx))
    else $error("one gated source did not reach exactly one pin");

  chk_pin_mapping:
    assert property (1'b1 |=>
                     (!(st_reg.pend[BIT_MAILBOX0] && st_reg.gate[BIT_MAILBOX0])
                      || st_reg.intx[$past(pin_map[BIT_MAILBOX0*SEL_W +: SEL_W])]))
    else $error("mailbox source missing on its mapped pin");

  chk_clear_w1c:
    assert property (((clr_bits != '0) && ((clr_bits & src_event) == '0)) |=>
                     ((st_reg.pend & $past(clr_bits)) == '0))
    else $error("written clear bit left its flag pending");

  chk_set_wins:
    assert property (((clr_bits & src_event & st_next.en) != '0) |=>
                     ((st_reg.pend & $past(clr_bits & src_event & st_next.en)) != '0))
    else $error("event lost to a clear in the same cycle");

  chk_reserved_zero:
    assert property (((st_reg.en | st_reg.gate) & ~VALID_BITS) == '0)
    else $error("reserved enable or gate bit is set");

  chk_flags_read:
    assert property ((setup_rd && apb_req.paddr == OFS_PENDING_FLAGS) |=>
                     (apb_rsp.prdata == $past(st_reg.pend)))
    else $error("flag read returned wrong data");

  chk_enable_write:
    assert property ((acc_wr && apb_req.paddr == OFS_SOURCE_ENABLE &&
                      apb_req.pstrb == 4'hf) |=>
                     (st_reg.en == ($past(apb_req.pwdata) & VALID_BITS)))
    else $error("enable register did not take the written value");

  chk_irq_masked:
    assert property ((st_reg.mask == '0) |-> !irq)
    else $error("host interrupt raised with mask all clear");

endmodule

// file: logic/lier_pkg.sv
// Purpose: constants and types of the local interrupt gating stage
// Assumes: APB slave, 32-bit data, one clock
// Notes:   offsets are byte addresses inside the register group

package lier_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  localparam logic [ADDR_W-1:0] OFS_SOURCE_ENABLE = 12'h448;
  localparam logic [ADDR_W-1:0] OFS_PIN_GATE      = 12'h44c;
  localparam logic [ADDR_W-1:0] OFS_PENDING_FLAGS = 12'h450;
  localparam logic [ADDR_W-1:0] OFS_PENDING_CLEAR = 12'h454;
  localparam logic [ADDR_W-1:0] OFS_HOST_MASK     = 12'h458;

  localparam int unsigned BIT_DMA_CH1 = 25;
  localparam int unsigned BIT_DMA_CH0 = 24;
  localparam int unsigned BIT_LOCMON3 = 23;
  localparam int unsigned BIT_LOCMON0 = 20;
  localparam int unsigned BIT_MAILBOX3 = 19;
  localparam int unsigned BIT_MAILBOX0 = 16;
  localparam int unsigned BIT_HOST_ERR  = 13;
  localparam int unsigned BIT_BKPL_ERR  = 12;
  localparam int unsigned BIT_REQ_EDGE  = 11;
  localparam int unsigned BIT_ACK_EVT   = 10;
  localparam int unsigned BIT_SYS_FAIL  = 9;
  localparam int unsigned BIT_PWR_FAIL  = 8;
  localparam int unsigned BIT_LEVEL7    = 7;
  localparam int unsigned BIT_LEVEL1    = 1;
  localparam int unsigned LEVEL_CNT     = 7;

  function automatic logic [DATA_W-1:0] span(int unsigned lo, int unsigned hi);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int unsigned b = lo; b <= hi; b++) begin
      m[b] = 1'b1;
    end
    return m;
  endfunction

  localparam logic [DATA_W-1:0] EVENT_BITS = span(BIT_PWR_FAIL, BIT_HOST_ERR)
                                           | span(BIT_MAILBOX0, BIT_MAILBOX3)
                                           | span(BIT_LOCMON0, BIT_LOCMON3)
                                           | span(BIT_DMA_CH0, BIT_DMA_CH1);
  localparam logic [DATA_W-1:0] LEVEL_BITS = span(BIT_LEVEL1, BIT_LEVEL7);
  localparam logic [DATA_W-1:0] VALID_BITS = EVENT_BITS | LEVEL_BITS;

  localparam logic [DATA_W-1:0] RST_WORD   = 32'h0000_0000;
  localparam logic              RST_LINE   = 1'b1;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } lier_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } lier_apb_rsp_t;

endpackage

// file: logic/lier_sync.sv
// Purpose: three-stage synchroniser with agreement filter for request lines
// Assumes: lines idle high (active low), asynchronous to pclk
// Notes:   output moves only when stages two and three agree

`timescale 1ns/1ps

module lier_sync #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] line_n,
  output logic      [WIDTH-1:0] seen_n
);
  import lier_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] seen;
  } lier_sync_st_t;

  lier_sync_st_t st_reg;
  lier_sync_st_t st_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("lier_sync needs at least one line");
  end

  // First stage feeds only the second
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = line_n;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int unsigned i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.seen[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= {4*WIDTH{RST_LINE}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign seen_n = st_reg.seen;

endmodule

// file: sim/lier_host.sv
// Purpose: host end that watches the INTx requests
// Assumes: pins pulled up, pulled low while a request stands
// Notes:   hits are sticky so a short request is not missed

`timescale 1ns/1ps

module lier_host (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] intx_assert,
  input  wire logic       clr,
  output logic      [3:0] hits
);
  logic [3:0] pin_n;

  assign pin_n = ~intx_assert;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits <= 4'h0;
    end else if (clr) begin
      hits <= 4'h0;
    end else begin
      hits <= hits | ~pin_n;
    end
  end
endmodule

// file: sim/lier_top_bench.sv
// Purpose: self-checking bench of the interrupt gating stage
// Assumes: zero-wait APB slave, request lines idle high
// Notes:   rows hold source, pin, enable/gate and expected pins

`timescale 1ns/1ps

module lier_top_bench;
  import lier_pkg::*;
  logic          pclk;
  logic          presetn;
  lier_apb_req_t req;
  lier_apb_rsp_t apb_rsp;
  logic [31:0]   src_event;
  logic [7:1]    irq_line_n;
  logic [63:0]   pin_map;
  logic [3:0]    intx_assert;
  logic          irq;
  logic          clr;
  logic [3:0]    hits;
  logic [31:0]   m;
  logic [19:0]   r;
  logic [3:0]    strb;
  int            n_mismatch;
  int            cmp_count;
  // Source bit, pin, {enable,gate}, expected pins
  localparam logic [19:0] ROWS [12] = '{20'h19031, 20'h18120, 20'h17234, 20'h14310,
    20'h13338, 20'h10234, 20'h0d132, 20'h0c020, 20'h0b031, 20'h0a100, 20'h09234, 20'h08338};
  localparam logic [11:0] OFS [5] = '{OFS_SOURCE_ENABLE, OFS_PIN_GATE, OFS_PENDING_FLAGS,
    OFS_PENDING_CLEAR, OFS_HOST_MASK};

  lier_top u_lier_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(apb_rsp),
    .src_event(src_event), .irq_line_n(irq_line_n), .pin_map(pin_map),
    .intx_assert(intx_assert), .irq(irq));
  lier_host u_lier_host (.pclk(pclk), .presetn(presetn), .intx_assert(intx_assert),
    .clr(clr), .hits(hits));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: strb};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 64);
    rdat = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  // One-cycle event; host hits cleared at the same edge
  task automatic pulse(input logic [31:0] v);
    @(posedge pclk);
    clr <= 1'b1;
    src_event <= v;
    @(posedge pclk);
    clr <= 1'b0;
    src_event <= 32'h0;
    @(negedge pclk);
    @(negedge pclk);
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    req = '0;
    src_event = '0;
    irq_line_n = 7'h7f;
    pin_map = '0;
    clr = 1'b0;
    strb = 4'hf;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(OFS[i], 32'h0, 1'b0);
    for (int i = 0; i < 5; i++) wr(OFS[i], 32'hffff_ffff);
    rd(OFS_SOURCE_ENABLE, VALID_BITS, 1'b0);
    rd(OFS_PIN_GATE, VALID_BITS, 1'b0);
    rd(OFS_PENDING_FLAGS, 32'h0, 1'b0);
    rd(OFS_PENDING_CLEAR, 32'h0, 1'b0);
    rd(12'h460, 32'h0, 1'b1);
    rd(12'h449, 32'h0, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      r = ROWS[i];
      m = 32'h1 << r[19:12];
      pin_map[2*r[19:12] +: 2] <= r[9:8];
      wr(OFS_SOURCE_ENABLE, r[5] ? m : 32'h0);
      wr(OFS_PIN_GATE, r[4] ? m : 32'h0);
      pulse(m);
      chk({28'h0, intx_assert}, {28'h0, r[3:0]});
      chk({28'h0, hits}, {28'h0, r[3:0]});
      chk({31'h0, irq}, {31'h0, r[5]});
      rd(OFS_PENDING_FLAGS, r[5] ? m : 32'h0, 1'b0);
      wr(OFS_PENDING_CLEAR, m);
      rd(OFS_PENDING_FLAGS, 32'h0, 1'b0);
    end
    $display("test rows done");
    m = 32'h0001_0000;
    wr(OFS_SOURCE_ENABLE, m);
    wr(OFS_PIN_GATE, m);
    pulse(m);
    wr(OFS_PENDING_CLEAR, 32'h0);
    wr(OFS_HOST_MASK, 32'h0);
    rd(OFS_PENDING_FLAGS, m, 1'b0);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_SOURCE_ENABLE, 32'h0);
    rd(OFS_PENDING_FLAGS, 32'h0, 1'b0);
    @(negedge pclk);
    chk({28'h0, intx_assert}, 32'h0);
    $display("test clear and mask done");
    pin_map <= '0;
    wr(OFS_SOURCE_ENABLE, LEVEL_BITS);
    wr(OFS_PIN_GATE, LEVEL_BITS);
    for (int k = 1; k < 8; k++) begin
      irq_line_n[k] <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(OFS_PENDING_FLAGS, 32'h1 << k, 1'b0);
      irq_line_n[k] <= 1'b1;
      @(negedge pclk);
      chk({28'h0, intx_assert}, 32'h1);
    end
    wr(OFS_PIN_GATE, 32'h0);
    irq_line_n[7] <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(OFS_PENDING_FLAGS, 32'h80, 1'b0);
    @(negedge pclk);
    chk({28'h0, intx_assert}, 32'h0);
    wr(OFS_SOURCE_ENABLE, 32'h0);
    rd(OFS_PENDING_FLAGS, 32'h0, 1'b0);
    $display("test levels done");
    wr(OFS_PIN_GATE, 32'hffff_ffff);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_PIN_GATE, 32'h0, 1'b0);
    chk({27'h0, irq, intx_assert}, 32'h0);
    // Only the strobed byte may land
    strb = 4'h4;
    wr(OFS_PIN_GATE, 32'hffff_ffff);
    strb = 4'hf;
    rd(OFS_PIN_GATE, 32'h00ff_0000, 1'b0);
    $display("test reset done");
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end
endmodule
